/* File: board_reset_model.sv */
// Board reset circuitry: pulls reset wires low and drives straps.
// Assumes pull-ups on the open-drain reset wires.
module board_reset_model
  import rst_seq_pkg::*;
(
  // Clock and device drives
  input wire logic clk,
  input wire logic hard_oe,
  input wire logic soft_oe,
  // Wire levels and straps
  output reset_pins_t pins,
  output logic [7:0] straps
);
  logic por_n = 1'b1;
  logic [1:0] pull = 2'h0;
  assign pins = '{por_n, !(pull[0] || hard_oe), !(pull[1] || soft_oe)};
  initial straps = 8'h00;
  // Low pulse on pin 0 por, 1 hard, 2 soft
  task automatic pulse(input int pin, input int len, input logic [7:0] val);
    @(posedge clk);
    straps <= val;
    @(posedge clk);
    if (pin == 0) por_n <= 1'b0;
    else pull[pin-1] <= 1'b1;
    repeat (len) @(posedge clk);
    por_n <= 1'b1;
    pull <= 2'h0;
    repeat (4) @(posedge clk);
    straps <= ~val;
  endtask
endmodule // board_reset_model

/* File: reset_qualifier.sv */
// Synchroniser and low-pulse qualifier for one active-low reset input.
// Assumes the input is asynchronous to the reference clock.
module reset_qualifier
  import rst_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and result
  input wire logic pin_n,
  output logic qualified
);
  logic sync1_reg;
  logic sync2_reg;
  logic [QCNT_W-1:0] cnt_reg;
  logic [QCNT_W-1:0] cnt_next;
  logic qualified_next;
  localparam logic [QCNT_W-1:0] QUAL_LAST = QCNT_W'(QUAL_CYCLES);

  // Count consecutive low samples, saturate at the qualification count
  assign cnt_next = sync2_reg ? QCNT_RESET : (cnt_reg == QUAL_LAST) ? cnt_reg : cnt_reg + 3'h1;
  assign qualified_next = !sync2_reg && (cnt_next == QUAL_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg <= QCNT_RESET;
      qualified <= 1'b0;
    end else begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
      cnt_reg <= cnt_next;
      qualified <= qualified_next;
    end
  end
endmodule // reset_qualifier

/* File: reset_sequence_timing.sv */
// Reset sequencer: qualifies reset pins, drives hard/soft reset, releases core fetch.
// Assumes one reference clock and open-drain reset pins resolved by the surroundings.
// Overview of operation
// - Hard reset output held asserted 26810 cycles after a qualified reset.
// - Soft reset output held at least 32 cycles counted from soft reset assertion in a hard reset sequence.
// - Core first fetch comes four cycles after soft reset release.
// - Soft reset falls one cycle after hard reset falls.
// - Qualified external soft reset keeps soft reset asserted at least one cycle.
module reset_sequence_timing
  import rst_seq_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Reset pins, open drain
  input wire logic POWER_ON_RESET_N,
  input wire logic HARD_RESET_N_IN,
  output logic HARD_RESET_N_OUT,
  output logic HARD_RESET_N_OE,
  input wire logic SOFT_RESET_N_IN,
  output logic SOFT_RESET_N_OUT,
  output logic SOFT_RESET_N_OE,
  // Reset configuration
  input wire logic [7:0] RESET_CONFIG_IN,
  output logic [7:0] RESET_CONFIG,
  // Core side
  output logic CORE_FETCH_EN,
  output logic CORE_IN_RESET
);
  typedef enum logic [2:0] {ST_IDLE, ST_HARD_ONLY, ST_HARD_SOFT, ST_SOFT_ONLY, ST_FETCH_WAIT, ST_RUN} state_t;

  localparam logic [CNT_W-1:0] HARD_LAST = CNT_W'(HARD_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] HR_SR_LAST = CNT_W'(HR_SR_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SOFT_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFT_MIN_LAST = CNT_W'(SOFT_MIN_CYCLES - 1);
  localparam logic [CNT_W-1:0] FETCH_LAST = CNT_W'(FETCH_DELAY_CYCLES - 1);

  reset_pins_t pins;
  reset_drive_t drive_next;
  state_t state_reg;
  state_t state_next;
  logic [CNT_W-1:0] hard_cnt_reg;
  logic [CNT_W-1:0] hard_cnt_next;
  logic [CNT_W-1:0] soft_cnt_reg;
  logic [CNT_W-1:0] soft_cnt_next;
  logic [CNT_W-1:0] soft_last_reg;
  logic [CNT_W-1:0] soft_last_next;
  logic por_q;
  logic hard_q;
  logic soft_q;
  logic por_q_d_reg;
  logic cfg_s1_reg;
  logic [7:0] cfg_sync1_reg;
  logic [7:0] cfg_sync2_reg;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic hard_req;
  logic soft_req;
  logic hard_done;
  logic soft_done;
  logic fetch_done;
  logic [2:0] hard_seen_reg;
  logic [2:0] soft_seen_reg;
  logic hard_masked;
  logic soft_masked;

  assign pins = '{power_on_reset_n: POWER_ON_RESET_N, hard_reset_n: HARD_RESET_N_IN, soft_reset_n: SOFT_RESET_N_IN};

  reset_qualifier u_por_qual (.clk(CORE_CLK), .rst_n(RESETN), .pin_n(pins.power_on_reset_n), .qualified(por_q));
  reset_qualifier u_hard_qual (.clk(CORE_CLK), .rst_n(RESETN), .pin_n(pins.hard_reset_n),
    .qualified(hard_q));
  reset_qualifier u_soft_qual (.clk(CORE_CLK), .rst_n(RESETN), .pin_n(pins.soft_reset_n),
    .qualified(soft_q));

  // Own drive reads back on the wire and lingers three cycles in the synchroniser
  assign hard_masked = HARD_RESET_N_OE | (|hard_seen_reg);
  assign soft_masked = SOFT_RESET_N_OE | (|soft_seen_reg);

  assign hard_req = por_q | (hard_q & !hard_masked);
  assign soft_req = soft_q && !soft_masked &&
    (state_reg == ST_RUN || state_reg == ST_FETCH_WAIT || state_reg == ST_IDLE);

  assign hard_done = (hard_cnt_reg == HARD_LAST);
  assign soft_done = (soft_cnt_reg == soft_last_reg);
  assign fetch_done = (soft_cnt_reg == FETCH_LAST);

  always_comb begin
    state_next = state_reg;
    hard_cnt_next = hard_cnt_reg;
    soft_cnt_next = soft_cnt_reg;
    soft_last_next = soft_last_reg;
    if (hard_req) begin
      state_next = ST_HARD_ONLY;
      hard_cnt_next = CNT_RESET;
      soft_cnt_next = CNT_RESET;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_HARD_ONLY;
          hard_cnt_next = CNT_RESET;
          soft_cnt_next = CNT_RESET;
        end
        ST_HARD_ONLY: begin
          hard_cnt_next = hard_cnt_reg + 16'h0001;
          soft_cnt_next = soft_cnt_reg + 16'h0001;
          if (soft_cnt_reg == HR_SR_LAST) begin
            state_next = ST_HARD_SOFT;
            soft_cnt_next = CNT_RESET;
            soft_last_next = SOFT_LAST;
          end
        end
        ST_HARD_SOFT: begin
          hard_cnt_next = hard_done ? hard_cnt_reg : hard_cnt_reg + 16'h0001;
          soft_cnt_next = soft_done ? soft_cnt_reg : soft_cnt_reg + 16'h0001;
          if (hard_done) begin
            state_next = ST_SOFT_ONLY;
          end
        end
        ST_SOFT_ONLY: begin
          soft_cnt_next = soft_cnt_reg + 16'h0001;
          if (soft_done) begin
            state_next = ST_FETCH_WAIT;
            soft_cnt_next = CNT_RESET;
          end
        end
        ST_FETCH_WAIT: begin
          soft_cnt_next = soft_cnt_reg + 16'h0001;
          if (fetch_done) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          state_next = ST_RUN;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      if (soft_req) begin
        state_next = ST_SOFT_ONLY;
        soft_cnt_next = CNT_RESET;
        soft_last_next = SOFT_MIN_LAST;
      end
    end
  end

  assign drive_next.hard_oe = (state_next == ST_HARD_ONLY) || (state_next == ST_HARD_SOFT);
  assign drive_next.soft_oe = (state_next == ST_HARD_SOFT) || (state_next == ST_SOFT_ONLY);
  assign drive_next.core_fetch_enable = (state_next == ST_RUN);

  // Capture configuration on the release edge of a qualified power-on reset
  assign cfg_next = (por_q_d_reg && !por_q) ? cfg_sync2_reg : cfg_reg;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      hard_cnt_reg <= CNT_RESET;
      soft_cnt_reg <= CNT_RESET;
      soft_last_reg <= CNT_RESET;
      por_q_d_reg <= 1'b0;
      hard_seen_reg <= 3'h0;
      soft_seen_reg <= 3'h0;
      cfg_s1_reg <= 1'b0;
      cfg_sync1_reg <= CONFIG_RESET;
      cfg_sync2_reg <= CONFIG_RESET;
      cfg_reg <= CONFIG_RESET;
      HARD_RESET_N_OE <= 1'b1;
      SOFT_RESET_N_OE <= 1'b0;
      CORE_FETCH_EN <= 1'b0;
      CORE_IN_RESET <= 1'b1;
    end else begin
      state_reg <= state_next;
      hard_cnt_reg <= hard_cnt_next;
      soft_cnt_reg <= soft_cnt_next;
      soft_last_reg <= soft_last_next;
      por_q_d_reg <= por_q;
      hard_seen_reg <= {hard_seen_reg[1:0], HARD_RESET_N_OE};
      soft_seen_reg <= {soft_seen_reg[1:0], SOFT_RESET_N_OE};
      cfg_s1_reg <= 1'b1;
      cfg_sync1_reg <= RESET_CONFIG_IN;
      cfg_sync2_reg <= cfg_sync1_reg;
      cfg_reg <= cfg_next;
      HARD_RESET_N_OE <= drive_next.hard_oe;
      SOFT_RESET_N_OE <= drive_next.soft_oe;
      CORE_FETCH_EN <= drive_next.core_fetch_enable;
      CORE_IN_RESET <= !drive_next.core_fetch_enable;
    end
  end

  // Open-drain pins only ever drive low
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HARD_RESET_N_OUT <= 1'b0;
      SOFT_RESET_N_OUT <= 1'b0;
      RESET_CONFIG <= CONFIG_RESET;
    end else begin
      HARD_RESET_N_OUT <= 1'b0;
      SOFT_RESET_N_OUT <= 1'b0;
      RESET_CONFIG <= cfg_s1_reg ? cfg_next : CONFIG_RESET;
    end
  end
endmodule // reset_sequence_timing

/* File: rst_seq_pkg.sv */
// Constants and carrier types for the reset sequencer.
// Assumes a single reference clock domain; counts are in reference cycles.
package rst_seq_pkg;
  localparam int unsigned QUAL_CYCLES = 4;
  localparam int unsigned HARD_HOLD_CYCLES = 26810;
  localparam int unsigned SOFT_HOLD_CYCLES = 32;
  localparam int unsigned HR_SR_DELAY_CYCLES = 4;
  localparam int unsigned FETCH_DELAY_CYCLES = 4;
  localparam int unsigned SOFT_MIN_CYCLES = 1;
  localparam int CNT_W = 16;
  localparam int QCNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [QCNT_W-1:0] QCNT_RESET = 3'h0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  typedef struct packed {
    logic power_on_reset_n;
    logic hard_reset_n;
    logic soft_reset_n;
  } reset_pins_t;

  typedef struct packed {
    logic hard_oe;
    logic soft_oe;
    logic core_fetch_enable;
  } reset_drive_t;
endpackage : rst_seq_pkg

/* File: rst_seq_sva.sv */
// Port checker for the reset sequencer.
// Assumes it is bound onto reset_sequence_timing.
module rst_seq_sva
  import rst_seq_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Watched outputs
  input wire logic HARD_RESET_N_OE,
  input wire logic HARD_RESET_N_OUT,
  input wire logic SOFT_RESET_N_OE,
  input wire logic [7:0] RESET_CONFIG,
  input wire logic CORE_FETCH_EN,
  input wire logic CORE_IN_RESET
);
  logic [15:0] hold_reg;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Cycles the hard reset drive has stood
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) hold_reg <= 16'h0000;
    else hold_reg <= HARD_RESET_N_OE ? hold_reg + 16'h0001 : 16'h0000;
  end
  a_hard_hold_len: assert property ($fell(HARD_RESET_N_OE) |-> hold_reg >= HARD_HOLD_CYCLES)
    else $error("hard reset released early");
  a_soft_after_hard: assert property ($rose(HARD_RESET_N_OE) |-> ##4 SOFT_RESET_N_OE)
    else $error("soft reset not driven after hard reset");
  a_soft_hold_long: assert property ($rose(SOFT_RESET_N_OE) && HARD_RESET_N_OE |-> SOFT_RESET_N_OE[*8])
    else $error("soft reset dropped early");
  a_soft_outlasts_hard: assert property ($fell(SOFT_RESET_N_OE) |-> !HARD_RESET_N_OE)
    else $error("soft reset ended before hard reset");
  a_fetch_after_soft: assert property ($fell(SOFT_RESET_N_OE) |-> ##[3:5] CORE_FETCH_EN)
    else $error("fetch not enabled after soft reset");
  a_soft_blocks_fetch: assert property ($rose(SOFT_RESET_N_OE) |-> ##1 !CORE_FETCH_EN[*4])
    else $error("fetch too soon after soft reset");
  a_hard_blocks_fetch: assert property (HARD_RESET_N_OE |-> !CORE_FETCH_EN && !HARD_RESET_N_OUT)
    else $error("fetch or level wrong in hard reset");
  a_core_flag_pair: assert property (CORE_IN_RESET != CORE_FETCH_EN)
    else $error("core reset flag disagrees with fetch");
  a_config_capture: assert property ($changed(RESET_CONFIG) |-> HARD_RESET_N_OE)
    else $error("config changed outside reset");
endmodule // rst_seq_sva

/* File: tb_top.sv */
// Testbench for the reset sequencer.
// Assumes package, design, checker and board model compiled first.
module tb_top
  import rst_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  reset_pins_t pins;
  logic [7:0] straps, cfg;
  logic hard_oe, hard_out, soft_oe, soft_out, fetch, in_rst;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  reset_sequence_timing reset_sequence_timing_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .POWER_ON_RESET_N(pins.power_on_reset_n), .HARD_RESET_N_IN(pins.hard_reset_n), .HARD_RESET_N_OUT(hard_out),
    .HARD_RESET_N_OE(hard_oe), .SOFT_RESET_N_IN(pins.soft_reset_n), .SOFT_RESET_N_OUT(soft_out),
    .SOFT_RESET_N_OE(soft_oe), .RESET_CONFIG_IN(straps), .RESET_CONFIG(cfg), .CORE_FETCH_EN(fetch),
    .CORE_IN_RESET(in_rst));
  board_reset_model board_reset_model_i (.clk(CORE_CLK), .hard_oe(hard_oe), .soft_oe(soft_oe), .pins(pins),
    .straps(straps));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      summarize();
    end
  end
  // Measures hard hold, soft delay and fetch delay of one sequence
  task automatic run_seq(input bit exact);
    int hcnt = 0;
    int soft_at = 0;
    int gap = 0;
    repeat (20) if (hard_oe !== 1'b1) @(negedge CORE_CLK);
    while (hard_oe === 1'b1 && hcnt < 30000) begin
      if (soft_at == 0 && soft_oe === 1'b1) soft_at = hcnt;
      hcnt++;
      @(negedge CORE_CLK);
    end
    repeat (8) if (soft_oe === 1'b1) @(negedge CORE_CLK);
    while (fetch !== 1'b1 && gap < 20) begin
      gap++;
      @(negedge CORE_CLK);
    end
    if (exact) begin
      check("hard hold", hcnt, HARD_HOLD_CYCLES);
      check("soft delay", soft_at, HR_SR_DELAY_CYCLES);
      check("fetch delay", gap, FETCH_DELAY_CYCLES);
    end
    check("fetch", fetch, 1'b1);
    check("drive levels", {hard_out, soft_out, in_rst}, 3'h0);
  endtask
  task automatic short_pulses();
    board_reset_model_i.pulse(0, 3, 8'h3C);
    board_reset_model_i.pulse(1, 3, 8'h3C);
    board_reset_model_i.pulse(2, 3, 8'h3C);
    repeat (12) @(negedge CORE_CLK);
    check("hard after short", hard_oe, 1'b0);
    check("soft after short", soft_oe, 1'b0);
  endtask
  task automatic power_on();
    fork
      board_reset_model_i.pulse(0, 4, 8'hA5);
      run_seq(1'b1);
    join
    check("config", cfg, 8'hA5);
  endtask
  task automatic ext_resets();
    fork
      board_reset_model_i.pulse(2, 4, 8'h00);
      begin
        repeat (20) if (soft_oe !== 1'b1) @(negedge CORE_CLK);
        check("soft req", {soft_oe, hard_oe}, 2'b10);
      end
    join
    repeat (10) @(negedge CORE_CLK);
    check("fetch back", fetch, 1'b1);
    fork
      board_reset_model_i.pulse(1, 4, 8'h0F);
      run_seq(1'b1);
    join
    check("config kept", cfg, 8'hA5);
  endtask
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    run_seq(1'b0);
    short_pulses();
    power_on();
    ext_resets();
    summarize();
  end
endmodule // tb_top
bind reset_sequence_timing rst_seq_sva rst_seq_sva_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .HARD_RESET_N_OE(HARD_RESET_N_OE), .HARD_RESET_N_OUT(HARD_RESET_N_OUT), .SOFT_RESET_N_OE(SOFT_RESET_N_OE),
  .RESET_CONFIG(RESET_CONFIG), .CORE_FETCH_EN(CORE_FETCH_EN), .CORE_IN_RESET(CORE_IN_RESET));
